/* button_conditioner.sv */
/*
  one front-panel button: synchroniser, debounce and tap/hold split.
  assumes an active-low button pin and a one-cycle millisecond tick.
*/
`timescale 1ns/1ps
module button_conditioner #(
  parameter int DEBOUNCE_MS = console_pkg::DEBOUNCE_MS,
  parameter int HOLD_W = console_pkg::HOLD_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick_ms,
  input wire logic button_n,
  input wire logic [HOLD_W-1:0] tap_limit,
  output logic held,
  output logic press,
  output logic tap_release,
  output logic hold_release
);

  localparam logic [7:0] DB_LAST = 8'(DEBOUNCE_MS - 1);
  localparam logic [HOLD_W-1:0] HOLD_MAX = '1;

  logic [1:0] sync_q;
  logic [7:0] bounce_cnt;
  logic [HOLD_W-1:0] hold_cnt;

  wire raw = sync_q[1];
  wire differs = raw != held;
  // R21 debounce settle
  wire settled = differs && tick_ms && (bounce_cnt == DB_LAST);
  // R21 tap versus hold
  wire is_tap = hold_cnt < tap_limit;

  // ----------------------------------------------------------------
  // synchroniser and debounce
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_q <= '0;
      bounce_cnt <= '0;
      held <= 1'b0;
    end else begin
      sync_q <= {sync_q[0], ~button_n};
      if (!differs) begin
        bounce_cnt <= '0;
      end else if (tick_ms) begin
        bounce_cnt <= settled ? '0 : bounce_cnt + 8'h01;
      end
      if (settled) begin
        held <= raw;
      end
    end
  end

  // ----------------------------------------------------------------
  // press duration and edge pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_cnt <= '0;
      press <= 1'b0;
      tap_release <= 1'b0;
      hold_release <= 1'b0;
    end else begin
      press <= settled && raw;
      tap_release <= settled && !raw && is_tap;
      hold_release <= settled && !raw && !is_tap;
      if (settled && raw) begin
        hold_cnt <= '0;
      end else if (held && tick_ms && hold_cnt != HOLD_MAX) begin
        hold_cnt <= hold_cnt + 1'b1;
      end
    end
  end

endmodule : button_conditioner

/* console_control.sv */
/*
  console control: source select, button modes, talkback pre-empt,
  relay, status leds with boot sequence, apb status/tap registers.
  assumes dip switches, buttons and recovered clocks are async pins.
*/
// Functional notes
// R1 - two switches pick one of three digital inputs as source.
// R2 - recovered clock of chosen input is the master sync reference.
// R3 - chosen input's two audio channels feed the headphone routing.
// R4 - relay disabled mode keeps relay released always.
// R5 - follow-main relay mode energizes relay while main is active.
// R6 - follow-talkback mode energizes relay while talkback is active.
// R7 - on-air: active talkback forces main output muted.
// R8 - production: talkback never mutes main output.
// R9 - after power up light three leds in turn, then run.
// R10 - green main led shows main active in both system modes.
// R11 - on-air: red main led shows main muted.
// R12 - production: red main led stays off.
// R13 - push-to-mute: main active, muted only while button held.
// R14 - push-to-talk: main muted, active only while button held.
// R15 - alternate action: each press toggles main output.
// R16 - alternate and hybrid modes start muted at power up.
// R17 - hybrid: hold gives active until release, tap toggles latch.
// R18 - on-air latched main forced off by talkback, restored after.
// R19 - switch changes take effect at once during operation.
// R20 - talkback offers push-to-talk or hybrid, starts muted.
// R21 - buttons debounced; release before threshold is a tap.
// R22 - fixed field encodings; unused relay code means disabled.
`timescale 1ns/1ps
module console_control #(
  parameter int MS_CYCLES = console_pkg::MS_CYCLES,
  parameter int BOOT_STEP_MS = console_pkg::BOOT_STEP_MS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic input_select_sw_a,
  input wire logic input_select_sw_b,
  input wire logic relay_mode_sw_a,
  input wire logic relay_mode_sw_b,
  input wire logic system_mode_sw,
  input wire logic talkback_button_mode_sw,
  input wire logic main_button_mode_sw_a,
  input wire logic main_button_mode_sw_b,
  input wire logic main_button_n,
  input wire logic talkback_button_n,
  input wire logic rx_clk_aes3id,
  input wire logic rx_clk_bidir,
  input wire logic rx_clk_aes3,
  input wire logic rx_data_aes3id,
  input wire logic rx_data_bidir,
  input wire logic rx_data_aes3,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [console_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic sync_ref,
  output logic src_audio_data,
  output logic [1:0] input_select,
  output logic main_on,
  output logic talkback_on,
  output logic relay_energize,
  output logic led_main_green,
  output logic led_main_red,
  output logic led_talkback
);

  localparam int HW = console_pkg::HOLD_W;
  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);
  localparam logic [9:0] STEP_LAST = 10'(BOOT_STEP_MS - 1);

  // ----------------------------------------------------------------
  // button mode decode, shared by main and talkback
  // ----------------------------------------------------------------
  function automatic logic chan_active(console_pkg::btn_mode_e m,
                                       logic hold, logic latch, logic tap);
    case (m)
      console_pkg::BTN_MUTE: chan_active = !hold;
      console_pkg::BTN_TALK: chan_active = hold;
      console_pkg::BTN_ALT: chan_active = latch;
      default: chan_active = hold || latch || tap;
    endcase
  endfunction : chan_active

  function automatic logic chan_latch(console_pkg::btn_mode_e m,
                                      logic latch, logic pr,
                                      logic tap, logic hrel);
    case (m)
      console_pkg::BTN_ALT: chan_latch = pr ? !latch : latch;
      console_pkg::BTN_HYB: chan_latch = tap ? !latch : (hrel ? 1'b0 : latch);
      default: chan_latch = 1'b0;
    endcase
  endfunction : chan_latch

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] sw_meta;
  logic [7:0] sw_sync;
  logic [5:0] rx_meta;
  logic [5:0] rx_sync;

  always_ff @(posedge clk) begin
    if (rst) begin
      sw_meta <= '0;
      sw_sync <= '0;
      rx_meta <= '0;
      rx_sync <= '0;
    end else begin
      sw_meta <= {main_button_mode_sw_b, main_button_mode_sw_a,
                  talkback_button_mode_sw, system_mode_sw,
                  relay_mode_sw_b, relay_mode_sw_a,
                  input_select_sw_b, input_select_sw_a};
      sw_sync <= sw_meta;
      rx_meta <= {rx_data_aes3, rx_data_bidir, rx_data_aes3id,
                  rx_clk_aes3, rx_clk_bidir, rx_clk_aes3id};
      rx_sync <= rx_meta;
    end
  end

  // R19 live switch fields
  // R22 fixed field encodings
  wire console_pkg::src_sel_e src_sel = console_pkg::src_sel_e'(sw_sync[1:0]);
  wire console_pkg::relay_mode_e relay_mode =
    console_pkg::relay_mode_e'(sw_sync[3:2]);
  wire onair = sw_sync[4] == console_pkg::SYS_ONAIR;
  wire console_pkg::btn_mode_e tb_mode = (sw_sync[5] == console_pkg::TB_HYBRID) ?
    console_pkg::BTN_HYB : console_pkg::BTN_TALK;
  wire console_pkg::btn_mode_e main_mode =
    console_pkg::btn_mode_e'(sw_sync[7:6]);

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  // R1 one of three inputs; spare code falls back to the coax input
  wire src_bidir = src_sel == console_pkg::SRC_BIDIR;
  wire src_aes3 = src_sel == console_pkg::SRC_AES3;
  wire [1:0] next_input_select = src_bidir ? console_pkg::SRC_BIDIR :
    (src_aes3 ? console_pkg::SRC_AES3 : console_pkg::SRC_AES3ID);
  // R2 recovered clock becomes sync reference
  wire next_sync_ref = src_bidir ? rx_sync[1] : (src_aes3 ? rx_sync[2] : rx_sync[0]);
  // R3 audio channels of the chosen input
  wire next_audio = src_bidir ? rx_sync[4] : (src_aes3 ? rx_sync[5] : rx_sync[3]);

  // ----------------------------------------------------------------
  // millisecond tick and boot sequence
  // ----------------------------------------------------------------
  logic [15:0] div_cnt;
  logic tick_ms;
  logic [9:0] step_cnt;
  console_pkg::boot_e boot_state;
  console_pkg::boot_e next_boot;

  wire run = boot_state == console_pkg::BOOT_RUN;
  wire step_done = tick_ms && (step_cnt == STEP_LAST);

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt <= '0;
      tick_ms <= 1'b0;
    end else begin
      tick_ms <= div_cnt == MS_LAST;
      div_cnt <= (div_cnt == MS_LAST) ? '0 : div_cnt + 16'h0001;
    end
  end

  // R9 three leds in turn before running
  always_comb begin
    next_boot = boot_state;
    case (boot_state)
      console_pkg::BOOT_RED: if (step_done) next_boot = console_pkg::BOOT_GREEN;
      console_pkg::BOOT_GREEN: if (step_done) next_boot = console_pkg::BOOT_TALK;
      console_pkg::BOOT_TALK: if (step_done) next_boot = console_pkg::BOOT_RUN;
      default: next_boot = console_pkg::BOOT_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      boot_state <= console_pkg::BOOT_RED;
      step_cnt <= '0;
    end else begin
      boot_state <= next_boot;
      if (step_done) begin
        step_cnt <= '0;
      end else if (tick_ms && !run) begin
        step_cnt <= step_cnt + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // buttons
  // ----------------------------------------------------------------
  logic [HW-1:0] tap_limit;
  logic main_held;
  logic main_press;
  logic main_tap;
  logic main_hrel;
  logic tb_held;
  logic tb_press;
  logic tb_tap;
  logic tb_hrel;

  button_conditioner #(
    .DEBOUNCE_MS(console_pkg::DEBOUNCE_MS),
    .HOLD_W(HW)
  ) main_btn (
    .clk(clk),
    .rst(rst),
    .tick_ms(tick_ms),
    .button_n(main_button_n),
    .tap_limit(tap_limit),
    .held(main_held),
    .press(main_press),
    .tap_release(main_tap),
    .hold_release(main_hrel)
  );

  button_conditioner #(
    .DEBOUNCE_MS(console_pkg::DEBOUNCE_MS),
    .HOLD_W(HW)
  ) talk_btn (
    .clk(clk),
    .rst(rst),
    .tick_ms(tick_ms),
    .button_n(talkback_button_n),
    .tap_limit(tap_limit),
    .held(tb_held),
    .press(tb_press),
    .tap_release(tb_tap),
    .hold_release(tb_hrel)
  );

  // ----------------------------------------------------------------
  // channel states
  // ----------------------------------------------------------------
  logic main_latch;
  logic tb_latch;

  // R15 R17 latch update; buttons ignored during boot
  wire next_main_latch = run &&
    chan_latch(main_mode, main_latch, main_press, main_tap, main_hrel);
  // R20 talkback follows the same hold and tap handling
  wire next_tb_latch = run &&
    chan_latch(tb_mode, tb_latch, tb_press, tb_tap, tb_hrel);

  // R13 R14 R15 R17 channel activity from mode
  wire main_raw = run && chan_active(main_mode, main_held, main_latch, main_tap);
  wire tb_act = run && chan_active(tb_mode, tb_held, tb_latch, tb_tap);
  // R7 R8 R18 pre-empt only in on-air; latch kept so it resumes
  wire preempt = onair && tb_act;
  wire main_act = main_raw && !preempt;

  // R4 R5 R6 R22 relay follows the channel picked by the relay mode
  wire next_relay = (relay_mode == console_pkg::RELAY_MAIN) ? main_act :
    ((relay_mode == console_pkg::RELAY_TALK) ? tb_act : 1'b0);

  // R10 R11 R12 leds, overridden by boot sequence
  wire next_green = run ? main_act : (boot_state == console_pkg::BOOT_GREEN);
  wire next_red = run ? (onair && !main_act) : (boot_state == console_pkg::BOOT_RED);
  wire next_led_tb = run ? tb_act : (boot_state == console_pkg::BOOT_TALK);

  // R16 R20 latches clear at power up, so alternate, hybrid and talkback channels start muted
  always_ff @(posedge clk) begin
    if (rst) begin
      main_latch <= 1'b0;
      tb_latch <= 1'b0;
      main_on <= 1'b0;
      talkback_on <= 1'b0;
      relay_energize <= 1'b0;
      led_main_green <= 1'b0;
      led_main_red <= 1'b0;
      led_talkback <= 1'b0;
      sync_ref <= 1'b0;
      src_audio_data <= 1'b0;
      input_select <= console_pkg::SRC_AES3ID;
    end else begin
      main_latch <= next_main_latch;
      tb_latch <= next_tb_latch;
      main_on <= main_act;
      talkback_on <= tb_act;
      relay_energize <= next_relay;
      led_main_green <= next_green;
      led_main_red <= next_red;
      led_talkback <= next_led_tb;
      sync_ref <= next_sync_ref;
      src_audio_data <= next_audio;
      input_select <= next_input_select;
    end
  end

  // ----------------------------------------------------------------
  // apb slave: one wait-free access phase
  // ----------------------------------------------------------------
  wire setup = psel && !penable;
  wire done = psel && penable && pready;
  wire hit_status = paddr == console_pkg::STATUS_OFS;
  wire hit_tap = paddr == console_pkg::TAP_LIMIT_OFS;
  wire unmapped = !hit_status && !hit_tap;

  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[console_pkg::ST_MAIN] = main_on;
    status_word[console_pkg::ST_TALK] = talkback_on;
    status_word[console_pkg::ST_RELAY] = relay_energize;
    status_word[console_pkg::ST_RUN] = run;
    status_word[console_pkg::ST_SRC +: 2] = input_select;
    status_word[console_pkg::ST_SYS] = sw_sync[4];
    status_word[console_pkg::ST_MAIN_LATCH] = main_latch;
    status_word[console_pkg::ST_TALK_LATCH] = tb_latch;
  end

  wire [31:0] rd_word = hit_status ? status_word :
    (hit_tap ? {16'h0000, tap_limit} : 32'h0000_0000);

  // data captured in setup so the answer stands for the whole access
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      tap_limit <= console_pkg::TAP_LIMIT_RST;
    end else begin
      pready <= setup;
      pslverr <= setup && unmapped;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
      end
      // R21 threshold set by software
      if (done && pwrite && hit_tap) begin
        tap_limit <= pwdata[HW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_relay_disabled: assert property ( // R4
    (relay_mode == console_pkg::RELAY_OFF || relay_mode == console_pkg::RELAY_SPARE)
      |=> !relay_energize)
    else $error("relay moved while disabled");

  chk_relay_main: assert property ( // R5
    (relay_mode == console_pkg::RELAY_MAIN) |=> (relay_energize == main_on))
    else $error("relay does not follow main");

  chk_relay_talk: assert property ( // R6
    (relay_mode == console_pkg::RELAY_TALK) |=> (relay_energize == talkback_on))
    else $error("relay does not follow talkback");

  chk_onair_preempt: assert property ( // R7
    (onair && tb_act) |=> (talkback_on && !main_on))
    else $error("main not muted during talkback");

  chk_prod_indep: assert property ( // R8
    (!onair && main_raw) |=> main_on)
    else $error("main muted in production");

  chk_boot_onehot: assert property ( // R9
    !run |=> $onehot({led_main_red, led_main_green, led_talkback}))
    else $error("boot leds not one at a time");

  chk_green_led: assert property ( // R10
    run |=> (led_main_green == main_on))
    else $error("green led wrong");

  chk_red_led: assert property ( // R11
    (run && onair) |=> (led_main_red == !main_on))
    else $error("red led wrong on air");

  chk_red_prod: assert property ( // R12
    (run && !onair) |=> !led_main_red)
    else $error("red led lit in production");

  chk_ptm_idle: assert property ( // R13
    (run && main_mode == console_pkg::BTN_MUTE && !main_held && !preempt)
      |=> main_on)
    else $error("push-to-mute idle not active");

  chk_ptt_idle: assert property ( // R14
    (main_mode == console_pkg::BTN_TALK && !main_held) |=> !main_on)
    else $error("push-to-talk idle not muted");

  chk_alt_toggle: assert property ( // R15
    (run && main_mode == console_pkg::BTN_ALT && main_press)
      |=> (main_latch != $past(main_latch)))
    else $error("alternate press did not toggle");

  chk_sync_ref: assert property ( // R2
    src_aes3 |=> (sync_ref == $past(rx_sync[2])))
    else $error("sync reference not from chosen input");

  chk_apb_ready: assert property (
    setup |=> (pready ##1 !pready))
    else $error("apb ready not a single cycle");

  cov_boot_done: cover property ($rose(run));
  cov_hybrid_tap: cover property (
    main_mode == console_pkg::BTN_HYB && main_tap ##1 main_latch);
  cov_preempt_resume: cover property (
    main_latch && preempt ##[1:8] main_latch && !preempt);
  cov_tb_hybrid: cover property (tb_mode == console_pkg::BTN_HYB && tb_tap);

endmodule : console_control

/* console_mute_relay_control_tb_top.sv */
/*
  self-checking bench for console_control with a bouncing panel model.
  assumes short ms tick (8 cycles) and boot step (2 ms) parameters.
*/
`timescale 1ns/1ps
module console_mute_relay_control_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] src_sw = 2'h0, relay_sw = 2'h0, main_sw = 2'h0;
  logic sys_sw = 1'b0, talk_sw = 1'b0, main_cmd = 1'b0, talk_cmd = 1'b0;
  logic [2:0] rx_clk = 3'h0, rx_data = 3'h0, seen;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, r;
  logic pready, pslverr, sync_ref, src_audio_data, main_on, talkback_on, main_n, talk_n;
  logic relay_energize, led_main_green, led_main_red, led_talkback;
  logic [1:0] input_select, sel;
  int error_cnt = 0;
  int checks = 0;
  int order[4] = '{2, 0, 3, 1};

  always #12.5 clk = ~clk;

  panel_model panel (.clk(clk), .main_cmd(main_cmd), .talk_cmd(talk_cmd),
    .main_button_n(main_n), .talkback_button_n(talk_n));

  console_control #(.MS_CYCLES(8), .BOOT_STEP_MS(2)) uut (.clk(clk), .rst(rst),
    .input_select_sw_a(src_sw[0]), .input_select_sw_b(src_sw[1]),
    .relay_mode_sw_a(relay_sw[0]), .relay_mode_sw_b(relay_sw[1]),
    .system_mode_sw(sys_sw), .talkback_button_mode_sw(talk_sw),
    .main_button_mode_sw_a(main_sw[0]), .main_button_mode_sw_b(main_sw[1]),
    .main_button_n(main_n), .talkback_button_n(talk_n),
    .rx_clk_aes3id(rx_clk[0]), .rx_clk_bidir(rx_clk[1]), .rx_clk_aes3(rx_clk[2]),
    .rx_data_aes3id(rx_data[0]), .rx_data_bidir(rx_data[1]), .rx_data_aes3(rx_data[2]),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_ref(sync_ref),
    .src_audio_data(src_audio_data), .input_select(input_select), .main_on(main_on),
    .talkback_on(talkback_on), .relay_energize(relay_energize),
    .led_main_green(led_main_green), .led_main_red(led_main_red),
    .led_talkback(led_talkback));

  // ------------------------------------------------------------
  // shared tasks and expectations
  // ------------------------------------------------------------
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compare

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  // holds the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic step(input logic p, input logic exp);
    @(posedge clk);
    main_cmd <= p;
    cyc(120);
    compare(main_on, exp);
    compare(led_main_green, exp);
    compare(led_main_red, sys_sw ? 1'b0 : !exp);
  endtask : step

  task automatic tstep(input logic p, input logic exp_t, input logic exp_m);
    @(posedge clk);
    talk_cmd <= p;
    cyc(120);
    compare(talkback_on, exp_t);
    compare(led_talkback, exp_t);
    compare(main_on, exp_m);
  endtask : tstep

  function automatic logic exp_main(input int m, input int s);
    case (m)
      0: return s % 2 == 1;
      1: return s % 2 == 0;
      2: return (s / 2) % 2 == 0;
      default: return s % 2 == 0 || (s / 2) % 2 == 0;
    endcase
  endfunction : exp_main

  function automatic logic exp_relay(input logic [1:0] code, input logic m, input logic t);
    return code == 2'h1 ? m : (code == 2'h2 ? t : 1'b0);
  endfunction : exp_relay

  task automatic wrap_up();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hc4f7));
    repeat (2) @(posedge clk);
    compare(main_on, 1'b0);
    rst <= 1'b0;
    seen = 3'h0;
    for (int n = 0; n < 200; n++) begin
      @(negedge clk);
      seen = seen | {led_talkback, led_main_green, led_main_red};
      if (n < 20) compare(main_on, 1'b0);
    end
    compare(seen, 3'h7);
    apb(1'b0, 8'h00, 32'h0);
    compare(rd[3], 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    compare(rd, 32'h0000012c);
    apb(1'b1, 8'h04, 32'hffff0014);
    apb(1'b0, 8'h04, 32'h0);
    compare(rd, 32'h00000014);
    apb(1'b0, 8'h08, 32'h0);
    compare(rd, 32'h0);
    compare({31'h0, err}, 32'h1);
    $display("end of test: boot and registers");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      main_sw <= order[i][1:0];
      cyc(6);
      for (int s = 0; s < 6; s++) step(s % 2 == 0, exp_main(order[i], s));
    end
    @(posedge clk);
    main_sw <= 2'h3;
    step(1'b1, 1'b1);
    cyc(200);
    step(1'b0, 1'b0);
    $display("end of test: button modes");
    @(posedge clk);
    main_sw <= 2'h2;
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    tstep(1'b1, 1'b1, 1'b0);
    compare(led_main_red, 1'b1);
    tstep(1'b0, 1'b0, 1'b1);
    $display("end of test: talkback pre-empt");
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      @(posedge clk);
      src_sw <= r[1:0];
      rx_clk <= r[4:2];
      rx_data <= r[7:5];
      relay_sw <= i[1:0];
      sys_sw <= r[8];
      talk_cmd <= r[9];
      cyc(120);
      sel = (r[1:0] == 2'h3) ? 2'h0 : r[1:0];
      compare(input_select, sel);
      compare(sync_ref, rx_clk[sel]);
      compare(src_audio_data, rx_data[sel]);
      compare(main_on, r[8] || !r[9]);
      compare(relay_energize, exp_relay(i[1:0], r[8] || !r[9], r[9]));
    end
    tstep(1'b0, 1'b0, 1'b1);
    $display("end of test: random switches");
    @(posedge clk);
    sys_sw <= 1'b1;
    talk_sw <= 1'b1;
    tstep(1'b0, 1'b0, 1'b1);
    tstep(1'b1, 1'b1, 1'b1);
    tstep(1'b0, 1'b1, 1'b1);
    tstep(1'b1, 1'b1, 1'b1);
    tstep(1'b0, 1'b0, 1'b1);
    $display("end of test: talkback hybrid");
    wrap_up();
  end
endmodule : console_mute_relay_control_tb_top

/* console_pkg.sv */
/*
  shared constants, field encodings and state types of the console
  control block. assumes a 40 MHz system clock.
*/
package console_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int US_PER_S = 1_000_000;
  localparam int TICK_US = 1000;
  localparam int MS_CYCLES = CLK_HZ / (US_PER_S / TICK_US);
  localparam int DEBOUNCE_MS = 10;
  localparam int BOOT_STEP_MS = 250;
  localparam int HOLD_W = 16;
  localparam logic [HOLD_W-1:0] TAP_LIMIT_RST = 16'h012c;

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] TAP_LIMIT_OFS = 8'h04;
  localparam int ST_MAIN = 0;
  localparam int ST_TALK = 1;
  localparam int ST_RELAY = 2;
  localparam int ST_RUN = 3;
  localparam int ST_SRC = 4;
  localparam int ST_SYS = 6;
  localparam int ST_MAIN_LATCH = 7;
  localparam int ST_TALK_LATCH = 8;

  // ----------------------------------------------------------------
  // switch field encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_AES3ID = 2'h0,
    SRC_BIDIR = 2'h1,
    SRC_AES3 = 2'h2,
    SRC_SPARE = 2'h3
  } src_sel_e;

  typedef enum logic [1:0] {
    RELAY_OFF = 2'h0,
    RELAY_MAIN = 2'h1,
    RELAY_TALK = 2'h2,
    RELAY_SPARE = 2'h3
  } relay_mode_e;

  typedef enum logic [1:0] {
    BTN_MUTE = 2'h0,
    BTN_TALK = 2'h1,
    BTN_ALT = 2'h2,
    BTN_HYB = 2'h3
  } btn_mode_e;

  localparam logic SYS_ONAIR = 1'b0;
  localparam logic TB_HYBRID = 1'b1;

  typedef enum logic [1:0] {
    BOOT_RED = 2'h0,
    BOOT_GREEN = 2'h1,
    BOOT_TALK = 2'h3,
    BOOT_RUN = 2'h2
  } boot_e;

endpackage : console_pkg

/* panel_model.sv */
/*
  front-panel button pair with contact bounce on every change.
  assumes the bench sets the press commands right after a clock edge.
*/
`timescale 1ns/1ps
module panel_model (
  input wire logic clk,
  input wire logic main_cmd,
  input wire logic talk_cmd,
  output logic main_button_n = 1'b1,
  output logic talkback_button_n = 1'b1
);
  // ------------------------------------------------------------
  // chatter for five cycles, then settle active low
  // ------------------------------------------------------------
  logic [2:0] main_cnt = 3'h0;
  logic [2:0] talk_cnt = 3'h0;

  always_ff @(posedge clk) begin
    if (main_cnt != 3'h0) begin
      main_cnt <= main_cnt - 3'h1;
      main_button_n <= (main_cnt == 3'h1) ? ~main_cmd : ~main_button_n;
    end else if (main_button_n == main_cmd) begin
      main_cnt <= 3'h6;
    end
    if (talk_cnt != 3'h0) begin
      talk_cnt <= talk_cnt - 3'h1;
      talkback_button_n <= (talk_cnt == 3'h1) ? ~talk_cmd : ~talkback_button_n;
    end else if (talkback_button_n == talk_cmd) begin
      talk_cnt <= 3'h6;
    end
  end
endmodule : panel_model
